// *** scp_debounce.sv ***
// Short-current persistence filter: one event pulse per qualified condition
`timescale 1ns/10ps
`include "scp_defines.svh"
module scp_debounce #(
  parameter int STEP_CYC = `SCP_DEB_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cond,
  input wire logic [4:0] sel,
  output logic event_pulse
);
  // Target is sel times step in 21 bits; larger steps would overflow it
  if (STEP_CYC < 1 || STEP_CYC > 65535)
  begin : g_bad_step
    $error("STEP_CYC out of range");
  end
  scp_pkg::scp_db_state_e state_reg;
  logic [20:0] cnt_reg;
  logic [20:0] target;
  assign target = 21'(sel) * 21'(STEP_CYC);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= scp_pkg::SCP_DB_IDLE;
      cnt_reg <= 21'h000000;
      event_pulse <= 1'b0;
    end
    else
    begin
      event_pulse <= 1'b0;
      case (state_reg)
        scp_pkg::SCP_DB_IDLE:
        begin
          cnt_reg <= 21'h000001;
          if (cond)
          begin
            if (sel == 5'h00)
            begin
              event_pulse <= 1'b1;
              state_reg <= scp_pkg::SCP_DB_HELD;
            end
            else
              state_reg <= scp_pkg::SCP_DB_COUNT;
          end
        end
        scp_pkg::SCP_DB_COUNT:
        begin
          // Any drop restarts the whole wait
          if (!cond)
            state_reg <= scp_pkg::SCP_DB_IDLE; // R2
          else if (cnt_reg >= target)
          begin
            event_pulse <= 1'b1; // R2
            state_reg <= scp_pkg::SCP_DB_HELD;
          end
          else
            cnt_reg <= cnt_reg + 21'h000001;
        end
        default:
        begin
          if (!cond)
            state_reg <= scp_pkg::SCP_DB_IDLE;
        end
      endcase
    end
  end
endmodule : scp_debounce

// *** scp_defines.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH
`define SCP_OFF_DEBOUNCE 8'h04
`define SCP_OFF_GATE_ACT 8'h05
`define SCP_OFF_OVERHEAT 8'h06
`define SCP_RST_DEBOUNCE 8'h01
`define SCP_RST_GATE_ACT 8'h03
`define SCP_RST_OVERHEAT 8'h92
`define SCP_RST_SHORT_CFG 8'h81
`define SCP_DEB_MSB 4
`define SCP_ACT_HS 2
`define SCP_ACT_LSB 1
`define SCP_ACT_LSA 0
`define SCP_OT_EN 7
`define SCP_OT_LOCK 4
`define SCP_OT_TH_MSB 1
`define SCP_SC_EN_MSB 7
`define SCP_SC_EN_LSB 6
`define SCP_SC_EN_ON 2'b01
`define SCP_DEB_STEP_NS 32000
`define SCP_CLK_NS 100
`define SCP_DEB_STEP_CYC (`SCP_DEB_STEP_NS / `SCP_CLK_NS)
`endif

// *** scp_host_model.sv ***
// Host microcontroller model: register and balance-field writes
`timescale 1ns/10ps
module scp_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Balance field
  output logic bal_wr,
  output logic [7:0] bal_data
);
  initial
  begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    bal_wr = 1'b0;
    bal_data = 8'h00;
  end
  // Reserved bits go out at their power-on value of zero while reg_wr is high
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d & (a == 8'h04 ? 8'h1f : a == 8'h05 ? 8'h07 : 8'h93);
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic bal(input logic [7:0] d);
    @(negedge clk);
    bal_data = d;
    bal_wr = 1'b1;
    @(negedge clk);
    bal_wr = 1'b0;
  endtask : bal
endmodule : scp_host_model

// *** scp_pkg.sv ***
// Types shared by the protection configuration block
package scp_pkg;
  typedef enum logic [1:0] {
    SCP_OT_85C,
    SCP_OT_100C,
    SCP_OT_125C,
    SCP_OT_150C
  } scp_ot_thresh_e;
  typedef struct packed {
    logic high_side;
    logic low_side_b;
    logic low_side_a;
  } scp_gate_s;
  typedef enum logic [1:0] {
    SCP_DB_IDLE,
    SCP_DB_COUNT,
    SCP_DB_HELD
  } scp_db_state_e;
endpackage : scp_pkg

// *** scp_protect.sv ***
// Short-current gate actions and over-temperature balance lock configuration
// What this block does
// R1 - Five-bit debounce select, 32 us per step, zero means no debounce.
// R2 - Short event counts only after condition persists for whole debounce time.
// R3 - Host keeps reserved bits at power-on value when writing.
// R4 - High-side action bit writable only while high-side drive input low.
// R5 - On short event, high-side output held or forced off and latched.
// R6 - High-side latch released by falling edge of high-side drive input.
// R7 - Low-side B action bit writable only while its drive input low.
// R8 - On short event, low-side B output held or forced off and latched.
// R9 - Low-side B latch released by falling edge of its drive input.
// R10 - Low-side A action bit writable only while its drive input low.
// R11 - On short event, low-side A output held or forced off and latched.
// R12 - Low-side A latch released by falling edge of its drive input.
// R13 - Over-temperature detection runs only while enable bit 7 set; resets set.
// R14 - Overheat with lock bit set forces all balance switches off, locked.
// R15 - Balance lock clears only when host writes balance field as zero.
// R16 - Two-bit threshold code selects 85, 100, 125 or 150 C; reset 10.
// R17 - Short detection active only with enable code 01; reset code 10.
// R18 - Sense above threshold pulls open-drain interrupt low.
`timescale 1ns/10ps
`include "scp_defines.svh"
module scp_protect #(
  parameter int DEB_STEP_CYC = `SCP_DEB_STEP_CYC
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register port
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Short-current settings from setting 1 register
  input wire logic [7:0] SHORT_CFG,
  // Analog comparators
  input wire logic SHORT_SENSE_ABOVE,
  input wire logic [3:0] OVERHEAT_ABOVE,
  // Drive inputs
  input wire logic HIGH_SIDE_DRIVE_IN,
  input wire logic LOW_SIDE_B_DRIVE_IN,
  input wire logic LOW_SIDE_A_DRIVE_IN,
  // Gate outputs
  output logic HIGH_SIDE_GATE_OUT,
  output logic LOW_SIDE_B_GATE_OUT,
  output logic LOW_SIDE_A_GATE_OUT,
  // Cell balance
  input wire logic [7:0] BALANCE_SWITCH_CONTROL,
  input wire logic BALANCE_WR,
  output logic [7:0] BALANCE_SWITCH_OUT,
  // Status
  output logic OVERHEAT_EVENT,
  output logic SHORT_EVENT,
  output logic INTERRUPT_OUT_LOW_O,
  output logic INTERRUPT_OUT_LOW_OE
);
  // Refuse step counts the debounce counter cannot hold
  if (DEB_STEP_CYC < 1 || DEB_STEP_CYC > 65535)
  begin : g_bad_step
    $error("DEB_STEP_CYC out of range");
  end

  logic [4:0] debounce_select_reg;
  scp_pkg::scp_gate_s short_action_reg;
  logic overheat_detect_enable_reg;
  logic overheat_balance_lock_reg;
  scp_pkg::scp_ot_thresh_e overheat_threshold_reg;
  logic balance_locked_reg;
  scp_pkg::scp_gate_s gate_locked_reg;
  scp_pkg::scp_gate_s drive_meta_reg;
  scp_pkg::scp_gate_s drive_sync_reg;
  scp_pkg::scp_gate_s drive_prev_reg;
  scp_pkg::scp_gate_s drive_fall;
  logic short_meta_reg;
  logic short_sync_reg;
  logic [3:0] ot_meta_reg;
  logic [3:0] ot_sync_reg;
  logic short_active;
  logic short_event_pulse;
  logic overheat_now;

  // Drive and comparator pins pass two flops before use
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      drive_meta_reg <= '0;
      drive_sync_reg <= '0;
      drive_prev_reg <= '0;
      short_meta_reg <= 1'b0;
      short_sync_reg <= 1'b0;
      ot_meta_reg <= 4'h0;
      ot_sync_reg <= 4'h0;
    end
    else
    begin
      drive_meta_reg <= {HIGH_SIDE_DRIVE_IN, LOW_SIDE_B_DRIVE_IN, LOW_SIDE_A_DRIVE_IN};
      drive_sync_reg <= drive_meta_reg;
      drive_prev_reg <= drive_sync_reg;
      short_meta_reg <= SHORT_SENSE_ABOVE;
      short_sync_reg <= short_meta_reg;
      ot_meta_reg <= OVERHEAT_ABOVE;
      ot_sync_reg <= ot_meta_reg;
    end
  end

  assign drive_fall = drive_prev_reg & ~drive_sync_reg;

  // Debounce register
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      debounce_select_reg <= 5'(`SCP_RST_DEBOUNCE);
    else if (REG_WR && REG_ADDR == `SCP_OFF_DEBOUNCE)
      debounce_select_reg <= REG_WDATA[`SCP_DEB_MSB:0]; // R1
  end

  // Action bits accept writes only while their drive input is low
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      short_action_reg <= 3'(`SCP_RST_GATE_ACT);
    else if (REG_WR && REG_ADDR == `SCP_OFF_GATE_ACT)
    begin
      if (!drive_sync_reg.high_side)
        short_action_reg.high_side <= REG_WDATA[`SCP_ACT_HS]; // R4
      if (!drive_sync_reg.low_side_b)
        short_action_reg.low_side_b <= REG_WDATA[`SCP_ACT_LSB]; // R7
      if (!drive_sync_reg.low_side_a)
        short_action_reg.low_side_a <= REG_WDATA[`SCP_ACT_LSA]; // R10
    end
  end

  // Over-temperature register
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      overheat_detect_enable_reg <= 1'(`SCP_RST_OVERHEAT >> `SCP_OT_EN); // R13
      overheat_balance_lock_reg <= 1'(`SCP_RST_OVERHEAT >> `SCP_OT_LOCK);
      overheat_threshold_reg <= scp_pkg::scp_ot_thresh_e'(2'(`SCP_RST_OVERHEAT)); // R16
    end
    else if (REG_WR && REG_ADDR == `SCP_OFF_OVERHEAT)
    begin
      overheat_detect_enable_reg <= REG_WDATA[`SCP_OT_EN]; // R13
      overheat_balance_lock_reg <= REG_WDATA[`SCP_OT_LOCK];
      overheat_threshold_reg <= scp_pkg::scp_ot_thresh_e'(REG_WDATA[`SCP_OT_TH_MSB:0]); // R16
    end
  end

  // Reserved bits read back as zero; host keeps them so
  always_comb
  begin
    REG_RDATA = 8'h00; // R3
    if (REG_ADDR == `SCP_OFF_DEBOUNCE)
      REG_RDATA = {3'h0, debounce_select_reg};
    else if (REG_ADDR == `SCP_OFF_GATE_ACT)
      REG_RDATA = {5'h00, short_action_reg};
    else if (REG_ADDR == `SCP_OFF_OVERHEAT)
      REG_RDATA = {overheat_detect_enable_reg, 2'h0, overheat_balance_lock_reg, 2'h0,
                   overheat_threshold_reg};
  end

  assign short_active = SHORT_CFG[`SCP_SC_EN_MSB:`SCP_SC_EN_LSB] == `SCP_SC_EN_ON; // R17

  scp_debounce #(
    .STEP_CYC(DEB_STEP_CYC)
  ) u_debounce (
    .clk(REF_CLK),
    .rst(RST),
    .cond(short_sync_reg && short_active),
    .sel(debounce_select_reg),
    .event_pulse(short_event_pulse)
  );

  // Latch offs; a new event beats a release in the same cycle
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      gate_locked_reg <= '0;
    else
    begin
      if (short_event_pulse && short_action_reg.high_side)
        gate_locked_reg.high_side <= 1'b1; // R5
      else if (drive_fall.high_side)
        gate_locked_reg.high_side <= 1'b0; // R6
      if (short_event_pulse && short_action_reg.low_side_b)
        gate_locked_reg.low_side_b <= 1'b1; // R8
      else if (drive_fall.low_side_b)
        gate_locked_reg.low_side_b <= 1'b0; // R9
      if (short_event_pulse && short_action_reg.low_side_a)
        gate_locked_reg.low_side_a <= 1'b1; // R11
      else if (drive_fall.low_side_a)
        gate_locked_reg.low_side_a <= 1'b0; // R12
    end
  end

  // Gate outputs follow drive unless locked; action 0 leaves them alone
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      HIGH_SIDE_GATE_OUT <= 1'b0;
      LOW_SIDE_B_GATE_OUT <= 1'b0;
      LOW_SIDE_A_GATE_OUT <= 1'b0;
    end
    else
    begin
      HIGH_SIDE_GATE_OUT <= drive_sync_reg.high_side && !gate_locked_reg.high_side; // R5
      LOW_SIDE_B_GATE_OUT <= drive_sync_reg.low_side_b && !gate_locked_reg.low_side_b; // R8
      LOW_SIDE_A_GATE_OUT <= drive_sync_reg.low_side_a && !gate_locked_reg.low_side_a; // R11
    end
  end

  assign overheat_now = overheat_detect_enable_reg && ot_sync_reg[overheat_threshold_reg]; // R13

  // Lock set wins over a clearing write in the same cycle
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      balance_locked_reg <= 1'b0;
    else if (overheat_now && overheat_balance_lock_reg)
      balance_locked_reg <= 1'b1; // R14
    else if (BALANCE_WR && BALANCE_SWITCH_CONTROL == 8'h00)
      balance_locked_reg <= 1'b0; // R15
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      BALANCE_SWITCH_OUT <= 8'h00;
      OVERHEAT_EVENT <= 1'b0;
      SHORT_EVENT <= 1'b0;
      INTERRUPT_OUT_LOW_OE <= 1'b0;
    end
    else
    begin
      BALANCE_SWITCH_OUT <= balance_locked_reg ? 8'h00 : BALANCE_SWITCH_CONTROL; // R14
      OVERHEAT_EVENT <= overheat_now;
      SHORT_EVENT <= short_event_pulse;
      // Synchronized comparator, not debounced, drives the pin
      INTERRUPT_OUT_LOW_OE <= short_sync_reg && short_active; // R18
    end
  end

  assign INTERRUPT_OUT_LOW_O = 1'b0; // R18
endmodule : scp_protect

// *** scp_protect_properties.sv ***
// Port-level assertions for the protection configuration block
`timescale 1ns/10ps
module scp_protect_properties (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register port
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // Sense and drive
  input wire logic [7:0] SHORT_CFG,
  input wire logic SHORT_SENSE_ABOVE,
  input wire logic [3:0] OVERHEAT_ABOVE,
  input wire logic HIGH_SIDE_DRIVE_IN,
  input wire logic HIGH_SIDE_GATE_OUT,
  // Balance and status
  input wire logic [7:0] BALANCE_SWITCH_CONTROL,
  input wire logic [7:0] BALANCE_SWITCH_OUT,
  input wire logic OVERHEAT_EVENT,
  input wire logic SHORT_EVENT,
  input wire logic INTERRUPT_OUT_LOW_OE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  unmapped_zero_a: assert property (REG_ADDR > 8'h06 |-> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  debounce_readback_a: assert property ((REG_WR && REG_ADDR == 8'h04 ##1 REG_ADDR == 8'h04)
    |-> REG_RDATA == {3'h0, $past(REG_WDATA[4:0])}) else $error("debounce readback");
  event_pulse_a: assert property (SHORT_EVENT |=> !SHORT_EVENT)
    else $error("short event too long");
  event_cause_a: assert property (!SHORT_SENSE_ABOVE [*5] |-> !SHORT_EVENT)
    else $error("short event without sense");
  short_disabled_a: assert property ((SHORT_CFG[7:6] != 2'b01) [*4] |-> !SHORT_EVENT)
    else $error("short event while disabled");
  gate_needs_drive_a: assert property (!HIGH_SIDE_DRIVE_IN [*4] |-> !HIGH_SIDE_GATE_OUT)
    else $error("gate on without drive");
  overheat_cause_a: assert property ((OVERHEAT_ABOVE == 4'h0) [*4] |-> !OVERHEAT_EVENT)
    else $error("overheat without comparator");
  balance_pass_a: assert property (BALANCE_SWITCH_OUT != 8'h00
    |-> BALANCE_SWITCH_OUT == $past(BALANCE_SWITCH_CONTROL)) else $error("balance value");
  pin_quiet_a: assert property (!SHORT_SENSE_ABOVE [*4] |-> !INTERRUPT_OUT_LOW_OE)
    else $error("interrupt pin pulled without sense");
endmodule : scp_protect_properties

bind scp_protect scp_protect_properties scp_protect_properties_inst (.*);

// *** testbench.sv ***
// Self-checking bench for the protection configuration block
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] short_cfg = 8'h41;
  logic sense = 1'b0;
  logic [3:0] hot = 4'h0;
  logic [2:0] drv = 3'h0;
  logic [2:0] gate, act;
  logic reg_wr, bal_wr, ot_ev, sc_ev;
  logic pin_o, pin_oe;
  logic [7:0] addr, wdata, rdata, bdat, bout, d;
  logic [7:0] rv [4] = '{8'h01, 8'h03, 8'h92, 8'h00};
  int miscompares = 0;
  int compares = 0;
  int evs = 0;
  int k, s, e;
  int mreg [3] = '{1, 3, 146};
  always #50 ref_clk = ~ref_clk;
  always @(negedge ref_clk)
    if (sc_ev === 1'b1)
      evs++;
  // Reference registers, updated from the rules on every write
  always @(posedge ref_clk or posedge rst)
    if (rst)
      mreg = '{1, 3, 146};
    else if (reg_wr === 1'b1 && addr == 8'h04)
      mreg[0] = int'(wdata) & 31;
    else if (reg_wr === 1'b1 && addr == 8'h05)
      mreg[1] = (mreg[1] & int'(drv)) | (int'(wdata) & 7 & ~int'(drv));
    else if (reg_wr === 1'b1 && addr == 8'h06)
      mreg[2] = int'(wdata) & 147;
  scp_protect #(.DEB_STEP_CYC(2)) scp_protect_inst (
    .REF_CLK(ref_clk), .RST(rst), .REG_WR(reg_wr), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .SHORT_CFG(short_cfg), .SHORT_SENSE_ABOVE(sense),
    .OVERHEAT_ABOVE(hot), .HIGH_SIDE_DRIVE_IN(drv[2]), .LOW_SIDE_B_DRIVE_IN(drv[1]),
    .LOW_SIDE_A_DRIVE_IN(drv[0]), .HIGH_SIDE_GATE_OUT(gate[2]),
    .LOW_SIDE_B_GATE_OUT(gate[1]), .LOW_SIDE_A_GATE_OUT(gate[0]),
    .BALANCE_SWITCH_CONTROL(bdat), .BALANCE_WR(bal_wr), .BALANCE_SWITCH_OUT(bout),
    .OVERHEAT_EVENT(ot_ev), .SHORT_EVENT(sc_ev), .INTERRUPT_OUT_LOW_O(pin_o),
    .INTERRUPT_OUT_LOW_OE(pin_oe));
  scp_host_model scp_host_model_inst (.clk(ref_clk), .reg_wr(reg_wr), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .bal_wr(bal_wr), .bal_data(bdat));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  // Bounded wait for the debounced event; counts edges from sense rising
  task automatic short_wait();
    k = 0;
    while (sc_ev !== 1'b1 && k < 100)
    begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 100)
    begin
      miscompares++;
      finish_test();
    end
  endtask : short_wait
  initial
  begin
    void'($urandom(32'hc91084cb));
    cyc(2);
    rst = 1'b0;
    for (int a = 0; a < 4; a++)
    begin
      scp_host_model_inst.rd(8'(a + 4), d);
      check(d, rv[a], "reset value");
    end
    for (int i = 0; i < 3; i++)
    begin
      s = (i == 0) ? 0 : (i == 1) ? 31 : int'(5'($urandom));
      scp_host_model_inst.wr(8'h04, 8'(s));
      scp_host_model_inst.rd(8'h04, d);
      check(d, 8'(mreg[0]), "debounce register");
      sense = 1'b1;
      short_wait();
      check(8'(k >= 2 * s + 2 && k <= 2 * s + 6), 8'h01, "debounce time");
      check({7'h0, pin_oe}, 8'h01, "interrupt pulled");
      check({7'h0, pin_o}, 8'h00, "interrupt level");
      sense = 1'b0;
      cyc(6);
    end
    // Excursion shorter than the debounce, then every disabled enable code
    scp_host_model_inst.wr(8'h04, 8'h04);
    e = evs;
    sense = 1'b1;
    cyc(3);
    sense = 1'b0;
    cyc(20);
    check(8'(evs - e), 8'h00, "short excursion");
    check({7'h0, pin_oe}, 8'h00, "interrupt released");
    for (int c = 0; c < 3; c++)
    begin
      short_cfg[7:6] = 2'(c + (c > 0));
      sense = 1'b1;
      cyc(20);
      check({7'h0, pin_oe}, 8'h00, "interrupt disabled");
      sense = 1'b0;
      cyc(4);
      check(8'(evs - e), 8'h00, "disabled short");
    end
    short_cfg = 8'h41;
    scp_host_model_inst.wr(8'h04, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      act = (i == 0) ? 3'h7 : 3'($urandom);
      drv = 3'h7;
      cyc(4);
      drv = 3'h0;
      cyc(4);
      scp_host_model_inst.wr(8'h05, {5'h0, act});
      drv = 3'h7;
      cyc(5);
      check({5'h0, gate}, 8'h07, "gate on");
      scp_host_model_inst.wr(8'h05, {5'h0, ~act});
      scp_host_model_inst.rd(8'h05, d);
      check(d, {5'h0, act}, "refused action write");
      check(d, 8'(mreg[1]), "action register");
      sense = 1'b1;
      short_wait();
      sense = 1'b0;
      cyc(4);
      check({5'h0, gate}, {5'h0, ~act}, "gate lock");
      drv = 3'h0;
      cyc(4);
      drv = 3'h7;
      cyc(5);
      check({5'h0, gate}, 8'h07, "gate release");
    end
    scp_host_model_inst.bal(8'h5a);
    for (int t = 0; t < 4; t++)
    begin
      scp_host_model_inst.wr(8'h06, 8'h90 | 8'(t));
      scp_host_model_inst.rd(8'h06, d);
      check(d, 8'(mreg[2]), "overheat register");
      hot = 4'hf ^ (4'h1 << t);
      cyc(5);
      check({7'h0, ot_ev}, 8'h00, "overheat below");
      hot = 4'h1 << t;
      cyc(5);
      check({7'h0, ot_ev}, 8'h01, "overheat above");
      check(bout, 8'h00, "balance locked");
      hot = 4'h0;
      scp_host_model_inst.bal(8'h5a);
      cyc(3);
      check(bout, 8'h00, "balance still locked");
      scp_host_model_inst.bal(8'h00);
      scp_host_model_inst.bal(8'h5a);
      cyc(3);
      check(bout, 8'h5a, "balance unlocked");
    end
    for (int j = 0; j < 2; j++)
    begin
      scp_host_model_inst.wr(8'h06, j ? 8'h82 : 8'h12);
      hot = 4'hf;
      cyc(5);
      check({7'h0, ot_ev}, 8'(j), "overheat enable");
      check(bout, 8'h5a, "balance kept");
      hot = 4'h0;
      cyc(4);
    end
    // Reset again mid-run: every setting must return to its power-on value
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    for (int a = 0; a < 4; a++)
    begin
      scp_host_model_inst.rd(8'(a + 4), d);
      check(d, rv[a], "reset again");
    end
    finish_test();
  end
endmodule : testbench
